// file: flash_guard_pkg.sv
// constants and types shared by the serial flash front end
package flash_guard_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_POWER_DOWN    = 8'hB9;
    localparam logic [7:0] OP_READ_ID       = 8'hAB;
    localparam logic [7:0] OP_SMALL_ERASE_A = 8'h20;
    localparam logic [7:0] OP_SMALL_ERASE_B = 8'hD7;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;
    localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;

    localparam int unsigned ADDR_W   = 24;
    localparam int unsigned BCNT_W   = 4;
    localparam int unsigned PU_CNT_W = 15;

    // byte counts of a frame, opcode included, and the last bit of a byte
    localparam logic [3:0] ONE_BYTE_FRAME     = 4'h1;
    localparam logic [3:0] STATUS_WRITE_BYTES = 4'h2;
    localparam logic [3:0] ADDR_FRAME_BYTES   = 4'h4;
    localparam logic [3:0] PROGRAM_MIN_BYTES  = 4'h5;
    localparam logic [3:0] BYTE_CNT_MAX       = 4'hF;
    localparam logic [2:0] LAST_BIT           = 3'h7;

    localparam int unsigned CLK_MHZ          = 50;
    localparam int unsigned POWER_UP_WAIT_US = 500;
    localparam int unsigned POWER_UP_WAIT_CYCLES =
        POWER_UP_WAIT_US * CLK_MHZ;

    localparam logic [3:0] PINS_RST = 4'hF;

    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_HOLD  = 2'b10
    } link_state_t;
endpackage

// file: pin_sync.sv
// two-flop synchronisers for the serial pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned     WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                meta_q[i] <= RST_VAL[i];
                q[i]      <= RST_VAL[i];
            end else begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end
endmodule

// file: serial_flash_hold_and_command_guard.sv
// serial front end: hold, power-up gating and malformed command guard
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01 - hold falling with clock low suspends
// RULE_02 - hold rising resumes where it stopped
// RULE_03 - host toggles hold only while clock low
// RULE_04 - hold needs select low; select rise resets
// RULE_05 - suspended: output off, clock and input ignored
// RULE_06 - host waits power-up delay before commands
// RULE_07 - start in standby; power-down only by command
// RULE_08 - partial byte at select rise discards command
// RULE_09 - page program needs whole data bytes
// RULE_10 - status write with two data bytes ignored
// RULE_11 - status write completion clears write enable
// RULE_12 - erase completion clears write enable
// RULE_13 - program completion clears write enable
// RULE_14 - id opcode, 24 dummy bits, id repeats
// RULE_15 - write enable opcode sets latch, needed first
// RULE_16 - power-down blocks all but id; busy ignores
// RULE_17 - discarded command changes no state
module serial_flash_hold_and_command_guard #(
    parameter int unsigned POWER_UP_CYCLES =
        flash_guard_pkg::POWER_UP_WAIT_CYCLES,
    // arbitrary identifier value
    parameter logic [7:0]  DEVICE_ID       = 8'h5A
) (
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    input  wire logic                              cs_n,
    input  wire logic                              sck,
    input  wire logic                              si,
    input  wire logic                              hold_n,
    output logic                                   so,
    output logic                                   so_oe,
    input  wire logic                              write_busy,
    input  wire logic                              write_done,
    output logic                                   wel,
    output logic                                   power_down,
    output logic                                   dev_ready,
    output logic [flash_guard_pkg::ADDR_W-1:0]     addr,
    output logic                                   small_erase_go,
    output logic                                   sector_erase_go,
    output logic                                   chip_erase_go,
    output logic                                   program_go,
    output logic [7:0]                             prog_byte,
    output logic                                   prog_byte_strobe,
    output logic                                   status_write_go,
    output logic [7:0]                             status_data
);
    import flash_guard_pkg::*;

    logic [3:0]          pins_s;
    logic                sck_p_q, hold_n_p_q;
    link_state_t         state_q, state_d;
    logic [2:0]          bit_q;
    logic [BCNT_W-1:0]   byte_cnt_q;
    logic [7:0]          sh_q, opcode_q;
    logic [PU_CNT_W-1:0] pu_cnt_q;
    logic                ready_q, wel_q, pd_q, id_out_q, so_q;
    logic [4:0]          go_q;

    pin_sync #(.WIDTH(4), .RST_VAL(PINS_RST)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({cs_n, sck, si, hold_n}),
        .q       (pins_s)
    );

    wire cs_n_s    = pins_s[3];
    wire sck_s     = pins_s[2];
    wire si_s      = pins_s[1];
    wire hold_n_s  = pins_s[0];
    wire sck_rise  = sck_s & ~sck_p_q;
    wire sck_fall  = ~sck_s & sck_p_q;
    wire hold_fall = ~hold_n_s & hold_n_p_q;
    wire hold_rise = hold_n_s & ~hold_n_p_q;
    wire idle      = (state_q == LINK_IDLE);
    wire shifting  = (state_q == LINK_SHIFT) & ~cs_n_s;
    wire cs_rise   = ~idle & cs_n_s;

    // clock and input only count while shifting, never while held
    wire       shift_en  = shifting & sck_rise & ready_q; // RULE_05
    wire       byte_done = shift_en & (bit_q == LAST_BIT);
    wire [7:0] byte_val  = {sh_q[6:0], si_s};
    wire       whole     = (bit_q == 3'h0);

    // evaluated only at select rise, so a frame cut mid-byte raises no go pulse
    wire cmd_ok = cs_rise & whole & ready_q & ~write_busy
                  & ~pd_q; // RULE_08 RULE_16
    wire wen_ok = cmd_ok & wel_q; // RULE_15
    wire n_one  = (byte_cnt_q == ONE_BYTE_FRAME);
    wire op_small = (opcode_q == OP_SMALL_ERASE_A)
                    | (opcode_q == OP_SMALL_ERASE_B);
    wire op_chip  = (opcode_q == OP_CHIP_ERASE_A)
                    | (opcode_q == OP_CHIP_ERASE_B);
    wire do_wren  = cmd_ok & n_one & (opcode_q == OP_WRITE_ENABLE);
    wire do_wrdi  = cmd_ok & n_one & (opcode_q == OP_WRITE_DISABLE);
    wire do_pd    = cmd_ok & n_one & (opcode_q == OP_POWER_DOWN);
    wire do_small = wen_ok & op_small & (byte_cnt_q == ADDR_FRAME_BYTES);
    wire do_sect  = wen_ok & (opcode_q == OP_SECTOR_ERASE)
                    & (byte_cnt_q == ADDR_FRAME_BYTES);
    wire do_chip  = wen_ok & op_chip & n_one;
    wire do_prog  = wen_ok & (opcode_q == OP_PAGE_PROGRAM)
                    & (byte_cnt_q >= PROGRAM_MIN_BYTES); // RULE_09
    wire do_srw   = wen_ok & (opcode_q == OP_STATUS_WRITE)
                    & (byte_cnt_q == STATUS_WRITE_BYTES); // RULE_10
    wire pd_exit  = byte_done & pd_q & (byte_cnt_q == '0)
                    & (byte_val == OP_READ_ID); // RULE_16
    wire id_phase = (opcode_q == OP_READ_ID) & ~write_busy
                    & (byte_cnt_q >= ADDR_FRAME_BYTES); // RULE_14
    wire pp_data  = byte_done & (opcode_q == OP_PAGE_PROGRAM) & wel_q
                    & ~pd_q & ~write_busy
                    & (byte_cnt_q >= ADDR_FRAME_BYTES);

    always_comb begin
        state_d = state_q;
        case (state_q)
            LINK_IDLE: begin
                if (!cs_n_s) state_d = LINK_SHIFT;
            end
            LINK_SHIFT: begin
                if (cs_n_s) state_d = LINK_IDLE; // RULE_04
                else if (hold_fall && !sck_s) state_d = LINK_HOLD; // RULE_01
            end
            LINK_HOLD: begin
                if (cs_n_s) state_d = LINK_IDLE; // RULE_04
                else if (hold_rise) state_d = LINK_SHIFT; // RULE_02
            end
            default: state_d = LINK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q    <= LINK_IDLE;
            sck_p_q    <= 1'b1;
            hold_n_p_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            sck_p_q    <= sck_s;
            hold_n_p_q <= hold_n_s;
        end
    end

    // counters survive a hold so the frame resumes mid-byte
    always_ff @(posedge clk) begin
        if (sys_rst || idle) begin
            bit_q      <= 3'h0; // RULE_04
            byte_cnt_q <= '0;
            sh_q       <= 8'h00;
        end else if (shift_en) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= byte_val;
            if (byte_done && byte_cnt_q != BYTE_CNT_MAX)
                byte_cnt_q <= byte_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opcode_q    <= 8'h00;
            addr        <= '0;
            status_data <= 8'h00;
            prog_byte   <= 8'h00;
        end else if (byte_done) begin
            if (byte_cnt_q == '0) opcode_q <= byte_val;
            if (byte_cnt_q != '0 && byte_cnt_q < ADDR_FRAME_BYTES)
                addr <= {addr[ADDR_W-9:0], byte_val};
            if (byte_cnt_q == ONE_BYTE_FRAME) status_data <= byte_val;
            if (pp_data) prog_byte <= byte_val;
        end
    end

    // host is trusted to hold off, but early frames are still dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pu_cnt_q <= '0;
            ready_q  <= 1'b0;
        end else if (!ready_q) begin
            pu_cnt_q <= pu_cnt_q + 1'b1;
            ready_q  <= (pu_cnt_q == PU_CNT_W'(POWER_UP_CYCLES - 1)); // RULE_06
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wel_q <= 1'b0;
            pd_q  <= 1'b0; // RULE_07
        end else begin
            if (do_wren) wel_q <= 1'b1; // RULE_15
            else if (write_done || do_wrdi) wel_q <= 1'b0; // RULE_11 RULE_12 RULE_13
            if (do_pd) pd_q <= 1'b1; // RULE_16
            else if (pd_exit) pd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            go_q             <= 5'h00;
            prog_byte_strobe <= 1'b0;
        end else begin
            go_q             <= {do_small, do_sect, do_chip, do_prog, do_srw}; // RULE_17
            prog_byte_strobe <= pp_data;
        end
    end

    // bit 7-n of each output byte leaves on the fall before rise n
    always_ff @(posedge clk) begin
        if (sys_rst || idle) begin
            so_q     <= 1'b0;
            id_out_q <= 1'b0;
        end else if (shifting && sck_fall && id_phase) begin
            so_q     <= DEVICE_ID[LAST_BIT - bit_q]; // RULE_14
            id_out_q <= 1'b1;
        end
    end

    assign so_oe           = id_out_q & shifting; // RULE_05
    assign so              = so_q;
    assign wel             = wel_q;
    assign power_down      = pd_q;
    assign dev_ready       = ready_q;
    assign small_erase_go  = go_q[4];
    assign sector_erase_go = go_q[3];
    assign chip_erase_go   = go_q[2];
    assign program_go      = go_q[1];
    assign status_write_go = go_q[0];

    wire any_go = |go_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_hold_enter: assert property ( // RULE_01
        shifting && hold_fall && !sck_s |=> state_q == LINK_HOLD)
        else $error("hold not entered");
    a_hold_resume: assert property ( // RULE_02
        state_q == LINK_HOLD && !cs_n_s && hold_rise
        |=> state_q == LINK_SHIFT && $stable(bit_q))
        else $error("hold not left or position lost");
    a_cs_resets: assert property ( // RULE_04
        cs_rise |=> idle ##1 (bit_q == 3'h0 && byte_cnt_q == '0))
        else $error("select rise did not reset link");
    a_held_quiet: assert property ( // RULE_05
        state_q == LINK_HOLD |-> !so_oe && !shift_en
        ##1 ($stable(bit_q) && $stable(byte_cnt_q)))
        else $error("activity while held");
    a_pd_cause: assert property ( // RULE_07
        $rose(pd_q) |-> $past(cs_rise) && !$past(write_busy)
        && $past(opcode_q) == OP_POWER_DOWN)
        else $error("power-down without command");
    a_partial_drop: assert property ( // RULE_08
        cs_rise && !whole |=> !any_go && $stable(wel_q) && $stable(pd_q))
        else $error("partial frame acted");
    a_prog_whole: assert property ( // RULE_09
        program_go |-> $past(bit_q) == 3'h0
        && $past(byte_cnt_q) >= PROGRAM_MIN_BYTES)
        else $error("program on broken frame");
    a_status_len: assert property ( // RULE_10
        status_write_go |-> $past(byte_cnt_q) == STATUS_WRITE_BYTES)
        else $error("status write with wrong length");
    a_wel_clear: assert property ( // RULE_11 RULE_12 RULE_13
        write_done && !do_wren |=> !wel_q)
        else $error("write enable not cleared");
    a_wel_needed: assert property ( // RULE_15
        any_go |-> $past(wel_q))
        else $error("write without enable");
    a_id_bit: assert property ( // RULE_14
        shifting && sck_fall && id_phase
        |=> so == DEVICE_ID[LAST_BIT - $past(bit_q)])
        else $error("wrong id bit");
    a_pd_blocks: assert property ( // RULE_16
        pd_q |=> !any_go && !$rose(wel_q))
        else $error("command accepted in power-down");
    a_drop_keeps: assert property ( // RULE_17
        cs_rise && !cmd_ok |=> !any_go && $stable(wel_q))
        else $error("dropped command changed state");

    c_hold_cycle: cover property (
        state_q == LINK_HOLD ##[1:100] state_q == LINK_SHIFT);
    c_program: cover property (program_go);
    c_id_out: cover property (so_oe ##8 so_oe);
    c_pd_exit: cover property (pd_q ##1 !pd_q);
endmodule

// file: serial_flash_hold_and_command_guard_tb.sv
// self-checking bench for the serial flash front end
`timescale 1ns/100ps
module serial_flash_hold_and_command_guard_tb;
    import flash_guard_pkg::*;
    localparam int unsigned PU = 20;
    // arbitrary identifier value
    localparam logic [7:0] ID = 8'h3C;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        write_busy = 1'b0;
    logic        write_done = 1'b0;
    logic        cs_n, sck, si, hold_n, so, so_oe;
    logic        wel, power_down, dev_ready;
    logic [23:0] addr;
    logic [7:0]  prog_byte, status_data;
    logic [5:0]  go;
    int          gcnt [6] = '{default: 0};
    int          errors = 0;
    int          tests_run = 0;
    logic [2:0]  r1;

    spi_host_model #(.PU_WAIT(PU)) i_spi_host_model (
        .clk(clk), .sys_rst(sys_rst), .so(so), .so_oe(so_oe),
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
    serial_flash_hold_and_command_guard #(
        .POWER_UP_CYCLES(PU), .DEVICE_ID(ID)
    ) i_serial_flash_hold_and_command_guard (
        .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .so(so), .so_oe(so_oe), .write_busy(write_busy),
        .write_done(write_done), .wel(wel), .power_down(power_down),
        .dev_ready(dev_ready), .addr(addr), .small_erase_go(go[0]),
        .sector_erase_go(go[1]), .chip_erase_go(go[2]),
        .program_go(go[3]), .prog_byte(prog_byte),
        .prog_byte_strobe(go[5]), .status_write_go(go[4]),
        .status_data(status_data));

    always #10 clk = ~clk;
    // pulses last one cycle, so count them as they pass
    always @(posedge clk)
        for (int k = 0; k < 6; k++)
            if (go[k] === 1'b1)
                gcnt[k]++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic frame(input logic [31:0] v, input int n);
        foreach (gcnt[k])
            gcnt[k] = 0;
        i_spi_host_model.start();
        i_spi_host_model.xfer(v, n);
        i_spi_host_model.stop();
    endtask
    task automatic finish_write();
        write_done = 1'b1;
        @(negedge clk);
        write_done = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic t_reset();
        check(wel, 0, "wel at reset");
        check(power_down, 0, "standby at reset");
        check(so_oe, 0, "so off at reset");
        repeat (PU - 2) @(negedge clk);
        check(dev_ready, 0, "not ready early");
        repeat (8) @(negedge clk);
        check(dev_ready, 1, "ready after wait");
        $display("test reset done");
    endtask
    task automatic t_wren();
        frame(OP_WRITE_ENABLE, 8);
        check(wel, 1, "enable sets latch");
        frame(OP_WRITE_DISABLE, 8);
        check(wel, 0, "disable clears");
        frame(OP_WRITE_ENABLE, 7);
        check(wel, 0, "partial byte dropped");
        $display("test write enable done");
    endtask
    task automatic t_status();
        frame({OP_STATUS_WRITE, 8'hA5}, 16);
        check(gcnt[4], 0, "status write needs latch");
        frame(OP_WRITE_ENABLE, 8);
        frame({OP_STATUS_WRITE, 8'hA5}, 16);
        check(gcnt[4], 1, "status write go");
        check(status_data, 8'hA5, "status data");
        finish_write();
        check(wel, 0, "status write clears");
        frame(OP_WRITE_ENABLE, 8);
        frame({OP_STATUS_WRITE, 8'hA5, 8'h5A}, 24);
        check(gcnt[4], 0, "long status write");
        check(wel, 1, "latch kept");
        frame(OP_WRITE_DISABLE, 8);
        $display("test status write done");
    endtask
    task automatic t_erase();
        logic [7:0] ops [5] = '{OP_SMALL_ERASE_A, OP_SMALL_ERASE_B,
                                OP_SECTOR_ERASE, OP_CHIP_ERASE_A,
                                OP_CHIP_ERASE_B};
        int idx [5] = '{0, 0, 1, 2, 2};
        for (int j = 0; j < 5; j++) begin
            frame(OP_WRITE_ENABLE, 8);
            if (j < 3)
                frame({ops[j], 24'h0ABCDE}, 32);
            else
                frame(ops[j], 8);
            check(gcnt[idx[j]], 1, "erase go");
            if (j < 3)
                check(addr, 24'h0ABCDE, "erase address");
            finish_write();
            check(wel, 0, "erase clears");
        end
        $display("test erase done");
    endtask
    task automatic t_program();
        for (int j = 0; j < 2; j++) begin
            frame(OP_WRITE_ENABLE, 8);
            gcnt[3] = 0;
            gcnt[5] = 0;
            i_spi_host_model.start();
            i_spi_host_model.xfer({OP_PAGE_PROGRAM, 24'h001234}, 32);
            i_spi_host_model.xfer(8'hC3, 8);
            i_spi_host_model.xfer(3'h5, 3 * j);
            i_spi_host_model.stop();
            check(gcnt[3], 1 - j, "program go");
            check(gcnt[5], 1, "data strobes");
            if (j == 0) begin
                check(prog_byte, 8'hC3, "program byte");
                check(addr, 24'h001234, "program address");
                finish_write();
            end
            check(wel, j, "latch after program");
        end
        frame(OP_WRITE_DISABLE, 8);
        $display("test page program done");
    endtask
    task automatic t_pd_hold();
        write_busy = 1'b1;
        frame(OP_POWER_DOWN, 8);
        write_busy = 1'b0;
        check(power_down, 0, "power-down while busy");
        frame(OP_POWER_DOWN, 8);
        check(power_down, 1, "power-down entered");
        frame(OP_WRITE_ENABLE, 8);
        check(wel, 0, "blocked in power-down");
        i_spi_host_model.start();
        i_spi_host_model.xfer({OP_READ_ID, 24'h0}, 32);
        check(power_down, 0, "id exits power-down");
        i_spi_host_model.xfer(0, 8);
        check(i_spi_host_model.rx[7:0], ID, "id byte");
        i_spi_host_model.xfer(0, 3);
        r1 = i_spi_host_model.rx[2:0];
        check(so_oe, 1, "driving before hold");
        i_spi_host_model.set_hold(1'b0);
        check(so_oe, 0, "so off in hold");
        i_spi_host_model.xfer(32'h5, 3);
        i_spi_host_model.set_hold(1'b1);
        i_spi_host_model.xfer(0, 5);
        check({r1, i_spi_host_model.rx[4:0]}, ID, "resume");
        i_spi_host_model.set_hold(1'b0);
        i_spi_host_model.stop();
        frame(OP_WRITE_ENABLE, 8);
        check(wel, 1, "select rise ends hold");
        i_spi_host_model.set_hold(1'b1);
        $display("test power-down and hold done");
    endtask

    initial begin
        #400_000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_wren();
        t_status();
        t_erase();
        t_program();
        t_pd_hold();
        end_sim();
    end
endmodule

// file: spi_host_model.sv
// host controller model that drives the serial pins of the flash front end
`timescale 1ns/100ps
module spi_host_model #(
    parameter int unsigned PU_WAIT = 20
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic so,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    int unsigned pu_cnt = 0;
    logic [31:0] rx = '0;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    always @(posedge clk) begin
        if (sys_rst)
            pu_cnt <= 0;
        else if (pu_cnt < PU_WAIT + 8)
            pu_cnt <= pu_cnt + 1;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // margin past the wait covers the pin synchronisers
    task automatic start();
        wait (pu_cnt >= PU_WAIT + 8);
        @(negedge clk);
        cs_n = 1'b0;
        idle(4);
    endtask
    // mode 0; so read late in the high phase, where it has settled
    task automatic xfer(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            si = v[i];
            idle(4);
            sck = 1'b1;
            idle(4);
            // a released line reads back inverted, so a lost enable shows
            rx = {rx[30:0], so_oe ? so : ~so};
            sck = 1'b0;
        end
    endtask
    task automatic stop();
        idle(4);
        cs_n = 1'b1;
        si = ~si;
        idle(10);
    endtask
    // the clock stands low between bits, so hold only moves then
    task automatic set_hold(input logic v);
        wait (sck == 1'b0);
        idle(1);
        hold_n = v;
        idle(6);
    endtask
endmodule
